/* File: inc/miu_pkg.sv */
// Package of constants shared by both ends of the meter interrupt unit.
package miu_pkg;
	// ****************************************************************
	// Register selectors on the register port.
	// ****************************************************************
	localparam logic [2:0] MIU_SEL_EN0   = 3'h0;
	localparam logic [2:0] MIU_SEL_EN1   = 3'h1;
	localparam logic [2:0] MIU_SEL_FLG0  = 3'h2;
	localparam logic [2:0] MIU_SEL_FLG1  = 3'h3;
	localparam logic [2:0] MIU_SEL_PIDLE = 3'h4;
	localparam logic [2:0] MIU_SEL_PEVT  = 3'h5;
	localparam logic [2:0] MIU_SEL_IPK   = 3'h6;
	localparam logic [2:0] MIU_SEL_VPK   = 3'h7;

	// ****************************************************************
	// Field positions and reset values.
	// ****************************************************************
	localparam int          MIU_WORD_W       = 32;
	localparam int          MIU_BIT_TOT_IDLE = 0;
	localparam int          MIU_BIT_FUN_IDLE = 1;
	localparam int          MIU_BIT_APP_IDLE = 2;
	localparam int          MIU_BIT_RST_DONE = 15;
	localparam int          MIU_BIT_DIP      = 16;
	localparam int          MIU_BIT_HI_CUR   = 17;
	localparam int          MIU_BIT_HI_VOLT  = 18;
	localparam int          MIU_BIT_CUR_PK   = 23;
	localparam int          MIU_BIT_VOLT_PK  = 24;
	localparam logic [31:0] MIU_EN_RESET     = 32'h0000_0000;
	localparam logic [31:0] MIU_FLG_RESET    = 32'h0000_0000;
	localparam logic [31:0] MIU_RST_DONE_MSK = 32'h0000_8000;
	localparam logic [31:0] MIU_SIGN_FLAGS   = 32'h0004_3fc0;
endpackage

/* File: inc/miu_if.sv */
// Interface joining the metering device end and the host end.
`timescale 1ns/100ps
interface miu_if;
	logic        irq_zero_n;
	logic        irq_one_n;
	logic        wr;
	logic        rd;
	logic [2:0]  sel;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        rvalid;

	modport dev (output irq_zero_n, output irq_one_n, input wr, input rd, input sel, input wdata,
		output rdata, output rvalid);
	modport host (input irq_zero_n, input irq_one_n, output wr, output rd, output sel, output wdata,
		input rdata, input rvalid);
endinterface

/* File: hw/miu_device.sv */
// Device end: enable words, flag words, companion state and the two interrupt lines.
`timescale 1ns/100ps
// Summary of operation
// [R1] Two interrupt lines, each with enable word
// [R2] Enable one passes event, zero blocks
// [R3] Events set matching flag bit
// [R4] Flags set regardless of enable
// [R5] Line low while enabled flag set
// [R6] Writing one clears flag bit
// [R7] Line stays low until flag cleared
// [R8] Enable words reset to zero
// [R9] Reset-complete enable bit has no effect
// [R10] Reset end sets reset-complete flag
// [R11] Idle flags paired with phase idle state
// [R12] Dip and high flags paired event state
// [R13] Peak flags paired with capture registers
// [R14] Sign flags paired with power sign state
// [R15] Host reads companion before clearing flag; code reads only the first-priority companion per service, none on line zero
// [R16] Host reads flag word of active line
// [R17] Host services falling edge, writes back
// [R18] Companion bits update with summary flag
// [R19] Idle flags set on enter and leave
// [R20] Zero writes keep flags; set beats clear
module miu_device
(
	miu_if.dev                        bus,              // Link to the host.
	input  wire logic                 i_clk,            // System clock.
	input  wire logic                 i_reset_n,        // Asynchronous reset, low.
	input  wire logic                 i_soft_reset_done,// Software reset finished, pulse.
	input  wire logic [31:0]          i_evt_zero,       // Events for flag word zero, pulses.
	input  wire logic [31:0]          i_evt_one,        // Other events for flag word one, pulses.
	input  wire logic [8:0]           i_phase_idle,     // Per-phase idle levels, three per kind.
	input  wire logic [8:0]           i_phase_evt,      // Per-phase dip/current/voltage event bits.
	input  wire logic [2:0]           i_phase_evt_strb, // Strobe per kind of phase_evt.
	input  wire logic [2:0]           i_cur_pk_phase,   // Phase of a current peak.
	input  wire logic                 i_cur_pk_strb,    // Current peak strobe.
	input  wire logic [2:0]           i_volt_pk_phase,  // Phase of a voltage peak.
	input  wire logic                 i_volt_pk_strb,   // Voltage peak strobe.
	input  wire logic [5:0]           i_power_sign,     // Per-phase power signs.
	output logic      [31:0]          o_power_sign_state// Sign state captured with sign flags.
);
	import miu_pkg::*;

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic [31:0] en0_r, en0_nxt, en1_r, en1_nxt;
	logic [31:0] flg0_r, flg0_nxt, flg1_r, flg1_nxt;
	logic [8:0]  pidle_r, pidle_nxt, pevt_r, pevt_nxt;
	logic [2:0]  ipk_r, ipk_nxt, vpk_r, vpk_nxt;
	logic [5:0]  sign_r, sign_nxt;
	logic        rst_pend_r, rst_pend_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] set0, set1, clr0, clr1;
	logic [2:0]  idle_chg;

	// Idle flags fire when any phase enters or leaves the idle state.
	always_comb
	begin
		for (int k = 0; k < 3; k++)
			idle_chg[k] = (i_phase_idle[3*k +: 3] != pidle_r[3*k +: 3]); // [R19]
	end

	// ****************************************************************
	// Next state of flags and companion registers.
	// ****************************************************************
	always_comb
	begin
		set0 = i_evt_zero; // [R3] [R4]
		set1 = i_evt_one & ~(32'h0180_0000 | 32'h0007_8007); // [R3] [R4]
		set1[MIU_BIT_TOT_IDLE] = idle_chg[0]; // [R11]
		set1[MIU_BIT_FUN_IDLE] = idle_chg[1]; // [R11]
		set1[MIU_BIT_APP_IDLE] = idle_chg[2]; // [R11]
		set1[MIU_BIT_RST_DONE] = rst_pend_r | i_soft_reset_done; // [R10]
		set1[MIU_BIT_DIP]      = i_phase_evt_strb[0]; // [R12]
		set1[MIU_BIT_HI_CUR]   = i_phase_evt_strb[1]; // [R12]
		set1[MIU_BIT_HI_VOLT]  = i_phase_evt_strb[2]; // [R12]
		set1[MIU_BIT_CUR_PK]   = i_cur_pk_strb; // [R13]
		set1[MIU_BIT_VOLT_PK]  = i_volt_pk_strb; // [R13]
		clr0 = (bus.wr && bus.sel == MIU_SEL_FLG0) ? bus.wdata : 32'h0; // [R6]
		clr1 = (bus.wr && bus.sel == MIU_SEL_FLG1) ? bus.wdata : 32'h0; // [R6]
		flg0_nxt = (flg0_r & ~clr0) | set0; // [R20]
		flg1_nxt = (flg1_r & ~clr1) | set1; // [R20] [R7]
		en0_nxt = (bus.wr && bus.sel == MIU_SEL_EN0) ? bus.wdata : en0_r; // [R1]
		en1_nxt = (bus.wr && bus.sel == MIU_SEL_EN1) ? bus.wdata : en1_r; // [R1]
		rst_pend_nxt = 1'b0;
		pidle_nxt = i_phase_idle; // [R18]
		pevt_nxt = pevt_r;
		for (int k = 0; k < 3; k++)
		begin
			if (i_phase_evt_strb[k])
				pevt_nxt[3*k +: 3] = i_phase_evt[3*k +: 3]; // [R18]
		end
		ipk_nxt = i_cur_pk_strb ? i_cur_pk_phase : ipk_r; // [R13]
		vpk_nxt = i_volt_pk_strb ? i_volt_pk_phase : vpk_r; // [R13]
		sign_nxt = |(set0 & MIU_SIGN_FLAGS) ? i_power_sign : sign_r; // [R14] [R18]
	end

	// ****************************************************************
	// Register read port, one cycle latency.
	// ****************************************************************
	always_comb
	begin
		rvalid_nxt = bus.rd;
		rdata_nxt = rdata_r;
		if (bus.rd)
		begin
			case (bus.sel)
				MIU_SEL_EN0:   rdata_nxt = en0_r;
				MIU_SEL_EN1:   rdata_nxt = en1_r;
				MIU_SEL_FLG0:  rdata_nxt = flg0_r;
				MIU_SEL_FLG1:  rdata_nxt = flg1_r;
				MIU_SEL_PIDLE: rdata_nxt = {23'h0, pidle_r};
				MIU_SEL_PEVT:  rdata_nxt = {23'h0, pevt_r};
				MIU_SEL_IPK:   rdata_nxt = {29'h0, ipk_r};
				MIU_SEL_VPK:   rdata_nxt = {29'h0, vpk_r};
				default:       rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			en0_r      <= MIU_EN_RESET; // [R8]
			en1_r      <= MIU_EN_RESET; // [R8]
			flg0_r     <= MIU_FLG_RESET;
			flg1_r     <= MIU_FLG_RESET;
			pidle_r    <= 9'h0;
			pevt_r     <= 9'h0;
			ipk_r      <= 3'h0;
			vpk_r      <= 3'h0;
			sign_r     <= 6'h0;
			rst_pend_r <= 1'b1; // [R10]
			rdata_r    <= 32'h0;
			rvalid_r   <= 1'b0;
		end
		else
		begin
			en0_r      <= en0_nxt;
			en1_r      <= en1_nxt;
			flg0_r     <= flg0_nxt;
			flg1_r     <= flg1_nxt;
			pidle_r    <= pidle_nxt;
			pevt_r     <= pevt_nxt;
			ipk_r      <= ipk_nxt;
			vpk_r      <= vpk_nxt;
			sign_r     <= sign_nxt;
			rst_pend_r <= rst_pend_nxt;
			rdata_r    <= rdata_nxt;
			rvalid_r   <= rvalid_nxt;
		end
	end

	// ****************************************************************
	// Interrupt lines, low while an enabled flag stands.
	// ****************************************************************
	assign bus.irq_zero_n = ~|(flg0_r & en0_r); // [R2] [R5] [R7]
	assign bus.irq_one_n  = ~|(flg1_r & (en1_r | MIU_RST_DONE_MSK)); // [R5] [R9] [R10]
	assign bus.rdata  = rdata_r;
	assign bus.rvalid = rvalid_r;
	assign o_power_sign_state = {26'h0, sign_r};
endmodule

/* File: hw/miu_host.sv */
// Host end: services falling edges on both lines, reads and writes back flag words.
`timescale 1ns/100ps
module miu_host
(
	miu_if.host                       bus,          // Link to the device.
	input  wire logic                 i_clk,        // System clock.
	input  wire logic                 i_reset_n,    // Asynchronous reset, low.
	input  wire logic                 i_cfg_wr,     // Write request for an enable word, pulse.
	input  wire logic                 i_cfg_line,   // Which enable word: 0 or 1.
	input  wire logic [31:0]          i_cfg_data,   // Enable word value.
	output logic                      o_cfg_ready,  // High when a request can be taken.
	output logic      [31:0]          o_flags,      // Last serviced flag word.
	output logic                      o_flags_line, // Line of last serviced flag word.
	output logic      [31:0]          o_companion,  // Last companion register read.
	output logic                      o_serviced    // One-cycle pulse when a service ends.
);
	import miu_pkg::*;

	typedef enum {MIU_IDLE, MIU_RD_FLG, MIU_WT_FLG, MIU_RD_CMP, MIU_WT_CMP, MIU_CLEAR} miu_state_e;

	miu_state_e  st_r, st_nxt;
	logic [1:0]  edge_r, edge_nxt;
	logic        z_r, o_r;
	logic        line_r, line_nxt;
	logic [31:0] flags_r, flags_nxt, comp_r, comp_nxt;
	logic [2:0]  csel_r, csel_nxt;
	logic        done_r, done_nxt;
	logic [3:0]  pick;

	// Pick the companion register that must be read before the clear.
	function automatic logic [3:0] miu_companion(input logic ln, input logic [31:0] f);
		logic [3:0] r;
		r = 4'h0;
		if (ln == 1'b0)
			r = 4'h0;
		else if (|f[2:0])
			r = {1'b1, MIU_SEL_PIDLE};
		else if (|f[18:16])
			r = {1'b1, MIU_SEL_PEVT};
		else if (f[MIU_BIT_CUR_PK])
			r = {1'b1, MIU_SEL_IPK};
		else if (f[MIU_BIT_VOLT_PK])
			r = {1'b1, MIU_SEL_VPK};
		return r;
	endfunction

	// Edge flags are kept set by new falling edges even while a service runs. [R17]
	always_comb
	begin
		pick = miu_companion(line_r, bus.rdata);
		edge_nxt = edge_r | {o_r & ~bus.irq_one_n, z_r & ~bus.irq_zero_n}; // [R17]
		st_nxt = st_r;
		line_nxt = line_r;
		flags_nxt = flags_r;
		comp_nxt = comp_r;
		csel_nxt = csel_r;
		done_nxt = 1'b0;
		bus.wr = 1'b0;
		bus.rd = 1'b0;
		bus.sel = MIU_SEL_EN0;
		bus.wdata = 32'h0;
		case (st_r)
			MIU_IDLE:
			begin
				if (i_cfg_wr)
				begin
					bus.wr = 1'b1;
					bus.sel = i_cfg_line ? MIU_SEL_EN1 : MIU_SEL_EN0;
					bus.wdata = i_cfg_data;
				end
				else if (|edge_r)
				begin
					line_nxt = edge_r[1] ? 1'b1 : 1'b0;
					edge_nxt[edge_r[1] ? 1 : 0] = 1'b0; // [R17]
					st_nxt = MIU_RD_FLG;
				end
			end
			MIU_RD_FLG:
			begin
				bus.rd = 1'b1;
				bus.sel = line_r ? MIU_SEL_FLG1 : MIU_SEL_FLG0; // [R16]
				st_nxt = MIU_WT_FLG;
			end
			MIU_WT_FLG:
			begin
				if (bus.rvalid)
				begin
					flags_nxt = bus.rdata;
					csel_nxt = pick[2:0];
					st_nxt = pick[3] ? MIU_RD_CMP : MIU_CLEAR;
				end
			end
			MIU_RD_CMP:
			begin
				bus.rd = 1'b1;
				bus.sel = csel_r; // [R15]
				st_nxt = MIU_WT_CMP;
			end
			MIU_WT_CMP:
			begin
				if (bus.rvalid)
				begin
					comp_nxt = bus.rdata;
					st_nxt = MIU_CLEAR;
				end
			end
			MIU_CLEAR:
			begin
				bus.wr = 1'b1;
				bus.sel = line_r ? MIU_SEL_FLG1 : MIU_SEL_FLG0;
				bus.wdata = flags_r; // [R6] [R15]
				done_nxt = 1'b1;
				st_nxt = MIU_IDLE;
			end
			default:
				st_nxt = MIU_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st_r    <= MIU_IDLE;
			edge_r  <= 2'h0;
			z_r     <= 1'b1;
			o_r     <= 1'b1;
			line_r  <= 1'b0;
			flags_r <= 32'h0;
			comp_r  <= 32'h0;
			csel_r  <= 3'h0;
			done_r  <= 1'b0;
		end
		else
		begin
			st_r    <= st_nxt;
			edge_r  <= edge_nxt;
			z_r     <= bus.irq_zero_n;
			o_r     <= bus.irq_one_n;
			line_r  <= line_nxt;
			flags_r <= flags_nxt;
			comp_r  <= comp_nxt;
			csel_r  <= csel_nxt;
			done_r  <= done_nxt;
		end
	end

	assign o_cfg_ready  = (st_r == MIU_IDLE);
	assign o_flags      = flags_r;
	assign o_flags_line = line_r;
	assign o_companion  = comp_r;
	assign o_serviced   = done_r;
endmodule

/* File: verif/miu_asserts.sv */
// Concurrent checks on the link between the device end and the host end.
`timescale 1ns/100ps
module miu_asserts
	import miu_pkg::*;
(
	input wire logic        i_clk,      // Clock.
	input wire logic        i_reset_n,  // Reset, low.
	input wire logic        irq_zero_n, // Line zero.
	input wire logic        irq_one_n,  // Line one.
	input wire logic        wr,         // Write strobe.
	input wire logic        rd,         // Read strobe.
	input wire logic [2:0]  sel,        // Select.
	input wire logic [31:0] wdata,      // Write data.
	input wire logic [31:0] rdata,      // Read data.
	input wire logic        rvalid      // Read answer.
);
	// ****
	// Shadow of enable word zero, rebuilt from the writes seen on the link.
	// ****
	logic [31:0] en0_r;
	logic [31:0] en0_nxt;
	always_comb en0_nxt = (wr && sel == MIU_SEL_EN0) ? wdata : en0_r;
	always_ff @(posedge i_clk or negedge i_reset_n)
		if (!i_reset_n)
			en0_r <= 32'h0;
		else
			en0_r <= en0_nxt;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	property p_read; rd |=> rvalid; endproperty
	a_read: assert property (p_read) else $error("read not answered");
	property p_rst; $rose(i_reset_n) |-> ##[0:2] !irq_one_n; endproperty
	a_rst: assert property (p_rst) else $error("no reset-complete line");
	property p_hold0; $rose(irq_zero_n) |-> $past(wr) && ($past(sel) == MIU_SEL_FLG0 || $past(sel) == MIU_SEL_EN0);
	endproperty
	a_hold0: assert property (p_hold0) else $error("line zero released alone");
	property p_hold1; $rose(irq_one_n) |-> $past(wr) && ($past(sel) == MIU_SEL_FLG1 || $past(sel) == MIU_SEL_EN1);
	endproperty
	a_hold1: assert property (p_hold1) else $error("line one released alone");
	property p_enable_word_zero; en0_r == 32'h0 |-> irq_zero_n; endproperty
	a_enable_word_zero: assert property (p_enable_word_zero) else $error("line zero low while disabled");
	property p_src1; $fell(irq_one_n) |-> ##[1:30] (rd && sel == MIU_SEL_FLG1); endproperty
	a_src1: assert property (p_src1) else $error("flag word one not read");
	property p_wb; rvalid && $past(sel) == MIU_SEL_FLG0 && rdata != 32'h0 |-> ##[1:8] (wr && sel == MIU_SEL_FLG0);
	endproperty
	a_wb: assert property (p_wb) else $error("flag word zero not written back");
	property p_cmp; rvalid && $past(sel) == MIU_SEL_FLG1 && rdata[0] |-> !wr throughout ##[1:6] (rd && sel == MIU_SEL_PIDLE);
	endproperty
	a_cmp: assert property (p_cmp) else $error("idle state not read first");
endmodule

/* File: verif/tb_meter_interrupt_unit.sv */
// Self-checking bench joining the device end and the host end.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_meter_interrupt_unit;
	import miu_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        srd = 1'b0;
	logic [31:0] ev0 = 32'h0;
	logic [31:0] ev1 = 32'h0;
	logic [8:0]  idle = 9'h0;
	logic [8:0]  pev = 9'h0;
	logic [2:0]  pst = 3'h0;
	logic [2:0]  cph = 3'h0;
	logic        cs = 1'b0;
	logic [2:0]  vph = 3'h0;
	logic        vs = 1'b0;
	logic [5:0]  psign = 6'h15;
	logic        cfg_wr = 1'b0;
	logic        cfg_line = 1'b0;
	logic [31:0] cfg_data = 32'h0;
	logic        ready;
	logic [31:0] flags;
	logic        fline;
	logic [31:0] comp;
	logic        serviced;
	logic [31:0] pss;
	int          err_count = 0;
	int          samples_checked = 0;
	miu_if bus_if ();
	miu_device u_miu_device (.bus(bus_if), .i_clk(i_clk), .i_reset_n(i_reset_n), .i_soft_reset_done(srd),
		.i_evt_zero(ev0), .i_evt_one(ev1), .i_phase_idle(idle), .i_phase_evt(pev), .i_phase_evt_strb(pst),
		.i_cur_pk_phase(cph), .i_cur_pk_strb(cs), .i_volt_pk_phase(vph), .i_volt_pk_strb(vs),
		.i_power_sign(psign), .o_power_sign_state(pss));
	miu_host u_miu_host (.bus(bus_if), .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg_wr(cfg_wr),
		.i_cfg_line(cfg_line), .i_cfg_data(cfg_data), .o_cfg_ready(ready), .o_flags(flags),
		.o_flags_line(fline), .o_companion(comp), .o_serviced(serviced));
	miu_asserts u_miu_asserts (.i_clk(i_clk), .i_reset_n(i_reset_n), .irq_zero_n(bus_if.irq_zero_n),
		.irq_one_n(bus_if.irq_one_n), .wr(bus_if.wr), .rd(bus_if.rd), .sel(bus_if.sel),
		.wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
	always #5 i_clk = ~i_clk;
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bound(input int n);
		if (n >= 200)
		begin
			err_count++;
			test_done();
		end
	endtask
	task automatic cfg(input logic l, input logic [31:0] d);
		int n;
		for (n = 0; n < 200 && ready !== 1'b1; n++)
			@(negedge i_clk);
		bound(n);
		@(posedge i_clk);
		cfg_wr <= 1'b1;
		cfg_line <= l;
		cfg_data <= d;
		@(posedge i_clk);
		cfg_wr <= 1'b0;
	endtask
	// ****
	// Waits for one service to end, then checks what the host saw.
	// ****
	task automatic svc(input logic [31:0] f, input logic l, input logic [31:0] c);
		int n;
		for (n = 0; n < 200 && serviced !== 1'b1; n++)
			@(negedge i_clk);
		bound(n);
		`CHK("flags", f, flags)
		`CHK("line", l, fline)
		`CHK("companion", c, comp)
		`CHK("irq", 2'b11, {bus_if.irq_zero_n, bus_if.irq_one_n})
		$display("test done: line %0d flags %h", l, f);
		@(negedge i_clk);
	endtask
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_reset_n <= 1'b1;
		svc(MIU_RST_DONE_MSK, 1'b1, 32'h0);
		cfg(1'b0, 32'h8);
		@(posedge i_clk) ev0 <= 32'h8;
		@(posedge i_clk) ev0 <= 32'h0;
		@(negedge i_clk) `CHK("interrupt_line_zero", 1'b0, bus_if.irq_zero_n)
		svc(32'h8, 1'b0, 32'h0);
		@(posedge i_clk) ev0 <= 32'h20;
		@(posedge i_clk) ev0 <= 32'h0;
		repeat (3) @(negedge i_clk);
		`CHK("interrupt_line_zero", 1'b1, bus_if.irq_zero_n)
		cfg(1'b0, 32'h28);
		svc(32'h20, 1'b0, 32'h0);
		cfg(1'b1, 32'h0181_0001);
		@(posedge i_clk) idle <= 9'h005;
		svc(32'h1, 1'b1, 32'h5);
		@(posedge i_clk) idle <= 9'h000;
		svc(32'h1, 1'b1, 32'h0);
		@(posedge i_clk) {pev, pst} <= {9'h002, 3'h1};
		@(posedge i_clk) pst <= 3'h0;
		svc(32'h1_0000, 1'b1, 32'h2);
		@(posedge i_clk) {cph, cs} <= {3'h4, 1'b1};
		@(posedge i_clk) cs <= 1'b0;
		svc(32'h80_0000, 1'b1, 32'h4);
		@(posedge i_clk) {vph, vs} <= {3'h2, 1'b1};
		@(posedge i_clk) vs <= 1'b0;
		svc(32'h100_0000, 1'b1, 32'h2);
		cfg(1'b0, 32'h40);
		@(posedge i_clk) ev0 <= 32'h40;
		@(posedge i_clk) ev0 <= 32'h0;
		svc(32'h40, 1'b0, 32'h2);
		`CHK("sign", 6'h15, pss[5:0])
		@(posedge i_clk) srd <= 1'b1;
		@(posedge i_clk) srd <= 1'b0;
		svc(MIU_RST_DONE_MSK, 1'b1, 32'h2);
		test_done();
	end
endmodule
